// [design/fac_pkg.sv]
// Constants and state types for the auxiliary flash command handler.
// Assumes a 100 MHz mclk and serial pins that are asynchronous to it.
package fac_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Opcodes; only the table read opcode is fixed by the interface
  localparam logic [7:0] OP_RB_ENABLE = 8'h70;
  localparam logic [7:0] OP_RB_DISABLE = 8'h80;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;

  // Framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
  localparam logic [1:0] NBYTES_ONE = 2'h1;
  localparam logic [1:0] NBYTES_MORE = 2'h2;

  // Reset recovery, least times
  localparam int TRCV_PROG_NS = 20000;
  localparam int TRCV_OTHER_NS = 12000;
  localparam int RCV_PROG_CYC = (TRCV_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCV_OTHER_CYC = (TRCV_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCV_W = 12;

  // Parameter table header area
  localparam logic [23:0] TABLE_HDR_SIZE = 24'h000018;
  localparam logic [7:0] TABLE_BLANK = 8'hFF;
  // Maker identifier: value is arbitrary
  localparam logic [7:0] MAKER_ID = 8'hA5;
  localparam logic [0:23][7:0] TABLE_HDR = {
    8'h53, 8'h46, 8'h44, 8'h50,  // signature
    8'h00, 8'h01, 8'h01, 8'hFF,  // minor, major, header count - 1
    8'h00, 8'h00, 8'h01, 8'h09,  // header 0: id, rev, length
    8'h30, 8'h00, 8'h00, 8'hFF,  // header 0: pointer
    MAKER_ID, 8'h00, 8'h01, 8'h04,  // header 1: id, rev, length
    8'h60, 8'h00, 8'h00, 8'hFF  // header 1: pointer
  };

  // Serial framing states, Gray along idle-opcode-address-dummy-data
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b011,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b110,
    ST_TAIL = 3'b111
  } fac_state_type;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_prev;
    logic si_s1;
    logic si_s2;
    fac_state_type st;
    logic [2:0] bitcnt;
    logic [1:0] addrcnt;
    logic [1:0] nbytes;
    logic [7:0] shin;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [6:0] shout;
    logic so;
    logic so_oe;
    logic rb_en;
    logic arm;
    logic rst_pulse;
    logic abort;
    logic rcv_busy;
    logic [RCV_W-1:0] rcv_cnt;
  } fac_regs_type;

endpackage

// [design/fac_cmd_handler.sv]
// Auxiliary command handler of a serial NOR flash: ready/busy output control,
// no-operation, two-step software reset and parameter table read.
// Assumes chip_select_n, sclk and si come from pins asynchronous to mclk,
// and that sclk runs well below a quarter of the mclk rate.
//
// Overview of operation
// - Enabled ready/busy drives serial output in program mode
// - Off-boundary deselect rejects enable/disable command
// - Disable command stops ready/busy on output
// - No-operation cancels armed reset
// - No-operation touches nothing else
// - Armed reset returns device to standby
// - Reset acts only after reset-arm command
// - Any command but reset or reset-arm disarms pending reset
// - Reset aborts running program or erase
// - Recovery after program lasts longer
// - Upper data lines ignored for these commands
// - Deselect ends table read at once
// - Table revision bytes read 00h and 01h
// - Header count byte reads 01h
// - First header: id 00h, 9 words, 30h
// - Second header: maker id, 4 words, 60h
`timescale 1ns/10ps

module fac_cmd_handler (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Serial pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic [2:0] upper_data_lines,
  output logic so,
  output logic so_oe,
  // Device core status
  input wire logic continuous_program_mode,
  input wire logic core_busy,
  input wire logic program_active,
  input wire logic erase_active,
  // Device core control
  output logic ready_busy_out_enable,
  output logic reset_armed,
  output logic soft_reset,
  output logic op_abort,
  output logic reset_recovering
);

  fac_pkg::fac_regs_type r_ff;
  fac_pkg::fac_regs_type nxt_r;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_in;
  logic [7:0] tbl_byte;
  logic on_boundary;

  // Edge detection compares second sync stages with their previous values
  assign sclk_rise = r_ff.sclk_s2 & ~r_ff.sclk_prev & ~r_ff.cs_s2;
  assign sclk_fall = ~r_ff.sclk_s2 & r_ff.sclk_prev & ~r_ff.cs_s2;
  assign cs_fall = ~r_ff.cs_s2 & r_ff.cs_prev;
  assign cs_rise = r_ff.cs_s2 & ~r_ff.cs_prev;
  // Only si is shifted; the upper data lines are never sampled
  assign byte_in = {r_ff.shin[6:0], r_ff.si_s2};
  // Exactly one opcode byte and no partial bits before deselect
  assign on_boundary = (r_ff.st == fac_pkg::ST_TAIL) && (r_ff.bitcnt == 3'h0) &&
                       (r_ff.nbytes == fac_pkg::NBYTES_ONE);

  // Header area of the table; undefined space reads blank
  always_comb begin
    if (r_ff.addr < fac_pkg::TABLE_HDR_SIZE) begin
      tbl_byte = fac_pkg::TABLE_HDR[r_ff.addr[4:0]];
    end else begin
      tbl_byte = fac_pkg::TABLE_BLANK;
    end
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cs_s1 = chip_select_n;
    nxt_r.cs_s2 = r_ff.cs_s1;
    nxt_r.cs_prev = r_ff.cs_s2;
    nxt_r.sclk_s1 = sclk;
    nxt_r.sclk_s2 = r_ff.sclk_s1;
    nxt_r.sclk_prev = r_ff.sclk_s2;
    nxt_r.si_s1 = si;
    nxt_r.si_s2 = r_ff.si_s1;
    nxt_r.rst_pulse = 1'b0;
    nxt_r.abort = 1'b0;

    // Recovery countdown after a software reset
    if (r_ff.rcv_busy) begin
      if (r_ff.rcv_cnt == '0) begin
        nxt_r.rcv_busy = 1'b0;
      end else begin
        nxt_r.rcv_cnt = r_ff.rcv_cnt - {{(fac_pkg::RCV_W-1){1'b0}}, 1'b1};
      end
    end

    if (cs_fall) begin
      nxt_r.st = fac_pkg::ST_OPCODE;
      nxt_r.bitcnt = 3'h0;
      nxt_r.nbytes = 2'h0;
    end else if (cs_rise) begin
      // Deselect ends any transfer immediately
      nxt_r.st = fac_pkg::ST_IDLE;
      // Commands executed at deselect are dropped during recovery; table reads still run
      if (on_boundary && !r_ff.rcv_busy) begin
        case (r_ff.opcode)
          fac_pkg::OP_RB_ENABLE: begin
            nxt_r.rb_en = 1'b1;
          end
          fac_pkg::OP_RB_DISABLE: begin
            nxt_r.rb_en = 1'b0;
          end
          fac_pkg::OP_RESET_ARM: begin
            nxt_r.arm = 1'b1;
          end
          fac_pkg::OP_RESET: begin
            if (r_ff.arm) begin
              // Back to standby with volatile state cleared
              nxt_r.arm = 1'b0;
              nxt_r.rb_en = 1'b0;
              nxt_r.rst_pulse = 1'b1;
              nxt_r.abort = program_active | erase_active;
              nxt_r.rcv_busy = 1'b1;
              // Program recovery is the longer of the two
              nxt_r.rcv_cnt = program_active ? fac_pkg::RCV_W'(fac_pkg::RCV_PROG_CYC - 1)
                                             : fac_pkg::RCV_W'(fac_pkg::RCV_OTHER_CYC - 1);
            end
          end
          default: begin
            // Nothing else is executed here
          end
        endcase
      end
    end else if (sclk_rise && r_ff.st != fac_pkg::ST_IDLE && r_ff.st != fac_pkg::ST_DATA) begin
      nxt_r.shin = byte_in;
      nxt_r.bitcnt = r_ff.bitcnt + 3'h1;
      if (r_ff.bitcnt == fac_pkg::BIT_LAST) begin
        case (r_ff.st)
          fac_pkg::ST_OPCODE: begin
            nxt_r.opcode = byte_in;
            nxt_r.nbytes = fac_pkg::NBYTES_ONE;
            // Any opcode but reset or reset-arm disarms; no-operation too
            if (byte_in != fac_pkg::OP_RESET && byte_in != fac_pkg::OP_RESET_ARM) begin
              nxt_r.arm = 1'b0;
            end
            if (byte_in == fac_pkg::OP_PARAM_READ) begin
              nxt_r.st = fac_pkg::ST_ADDR;
              nxt_r.addrcnt = 2'h0;
            end else begin
              nxt_r.st = fac_pkg::ST_TAIL;
            end
          end
          fac_pkg::ST_ADDR: begin
            nxt_r.addr = {r_ff.addr[15:0], byte_in};
            nxt_r.addrcnt = r_ff.addrcnt + 2'h1;
            if (r_ff.addrcnt == fac_pkg::ADDR_BYTE_LAST) begin
              nxt_r.st = fac_pkg::ST_DUMMY;
            end
          end
          fac_pkg::ST_DUMMY: begin
            nxt_r.st = fac_pkg::ST_DATA;
            nxt_r.bitcnt = 3'h0;
          end
          fac_pkg::ST_TAIL: begin
            nxt_r.nbytes = fac_pkg::NBYTES_MORE;
          end
          default: begin
            nxt_r.st = fac_pkg::ST_IDLE;
          end
        endcase
      end
    end else if (sclk_fall && r_ff.st == fac_pkg::ST_DATA) begin
      // Shift on the falling edge so the host samples on the rising one
      nxt_r.bitcnt = r_ff.bitcnt + 3'h1;
      if (r_ff.bitcnt == 3'h0) begin
        nxt_r.so = tbl_byte[7];
        nxt_r.shout = tbl_byte[6:0];
        nxt_r.addr = r_ff.addr + 24'h000001;
      end else begin
        nxt_r.so = r_ff.shout[6];
        nxt_r.shout = {r_ff.shout[5:0], 1'b0};
      end
    end

    // Output driver: table data, else ready/busy in program mode
    if (nxt_r.st == fac_pkg::ST_DATA && !cs_rise) begin
      nxt_r.so_oe = (r_ff.st == fac_pkg::ST_DATA) && (r_ff.so_oe || sclk_fall);
    end else if (r_ff.rb_en && continuous_program_mode) begin
      nxt_r.so_oe = 1'b1;
      nxt_r.so = ~core_busy;
    end else begin
      nxt_r.so_oe = 1'b0;
      nxt_r.so = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '0;
      r_ff.cs_s1 <= 1'b1;
      r_ff.cs_s2 <= 1'b1;
      r_ff.cs_prev <= 1'b1;
      r_ff.st <= fac_pkg::ST_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign so = r_ff.so;
  assign so_oe = r_ff.so_oe;
  assign ready_busy_out_enable = r_ff.rb_en;
  assign reset_armed = r_ff.arm;
  assign soft_reset = r_ff.rst_pulse;
  assign op_abort = r_ff.abort;
  assign reset_recovering = r_ff.rcv_busy;

endmodule

// [test/fac_cmd_asserts.sv]
// Checker for the auxiliary flash command handler.
// Assumes a bind onto fac_cmd_handler; sees its ports only.
`timescale 1ns/10ps
module fac_cmd_asserts (
  // Clock, reset and pins
  input wire logic mclk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic so,
  input wire logic so_oe,
  // Core side
  input wire logic continuous_program_mode,
  input wire logic core_busy,
  input wire logic program_active,
  input wire logic erase_active,
  input wire logic ready_busy_out_enable,
  input wire logic reset_armed,
  input wire logic soft_reset,
  input wire logic op_abort,
  input wire logic reset_recovering
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic prog_ff;
  logic [11:0] len_ff;
  int lim;
  // One cycle of slack for the sync phase
  assign lim = prog_ff ? fac_pkg::RCV_PROG_CYC : fac_pkg::RCV_OTHER_CYC;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prog_ff <= 1'b0;
      len_ff <= 12'h000;
    end else begin
      prog_ff <= soft_reset ? $past(program_active) : prog_ff;
      len_ff <= reset_recovering ? len_ff + 12'h001 : 12'h000;
    end
  end
  property p_rb_on;
    chip_select_n [*8] ##0 ready_busy_out_enable && continuous_program_mode |=> so_oe && so == !$past(core_busy);
  endproperty
  a_rb_on: assert property (p_rb_on) else $error("status not on output");
  property p_rb_off;
    chip_select_n [*8] ##0 !ready_busy_out_enable |=> !so_oe;
  endproperty
  a_rb_off: assert property (p_rb_off) else $error("output driven while disabled");
  property p_frame;
    // Disarm by a later opcode lands mid-frame by design; ready/busy changes, arming and resets wait for deselect
    $changed(ready_busy_out_enable) || $rose(reset_armed) || ($fell(reset_armed) && soft_reset)
      |-> $past(chip_select_n, 2);
  endproperty
  a_frame: assert property (p_frame) else $error("latch moved inside a frame");
  property p_arm;
    soft_reset |-> $past(reset_armed);
  endproperty
  a_arm: assert property (p_arm) else $error("reset without arm");
  property p_standby;
    soft_reset |-> !reset_armed && !ready_busy_out_enable ##1 !soft_reset;
  endproperty
  a_standby: assert property (p_standby) else $error("reset left state");
  property p_abort;
    soft_reset || op_abort |-> soft_reset && op_abort == $past(program_active || erase_active);
  endproperty
  a_abort: assert property (p_abort) else $error("abort mismatch");
  property p_rcv_start;
    soft_reset |=> reset_recovering [*8];
  endproperty
  a_rcv_start: assert property (p_rcv_start) else $error("no recovery");
  property p_rcv_len;
    $fell(reset_recovering) |-> len_ff >= lim && len_ff <= lim + 1;
  endproperty
  a_rcv_len: assert property (p_rcv_len) else $error("recovery length wrong");
  property p_read_end;
    $rose(chip_select_n) && !ready_busy_out_enable |-> ##[1:6] !so_oe;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read not ended");
  c_abort: cover property (soft_reset && op_abort);
  c_disarm: cover property ($fell(reset_armed) && !soft_reset);
  c_rb: cover property (so_oe && continuous_program_mode);
endmodule

// [test/fac_host_model.sv]
// Host serial flash controller model; frames by chip select.
// Assumes mclk at 100 MHz; sclk is 10 mclk long and idles low.
`timescale 1ns/10ps
module fac_host_model (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic chip_select_n,
  output logic sclk,
  output logic si,
  output logic [2:0] upper_data_lines,
  input wire logic so
);
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    upper_data_lines = 3'h0;
  end
  // Noise on lines the device must not read
  always @(posedge mclk) upper_data_lines <= upper_data_lines + 3'h1;
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic sel();
    chip_select_n <= 1'b0;
    tick(4);
  endtask
  // Released si shows the inverse of its last bit
  task automatic desel();
    tick(2);
    chip_select_n <= 1'b1;
    si <= ~si;
    tick(8);
  endtask
  // Sample so late in the low phase, clear of its update
  task automatic xb(logic [7:0] v, int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si <= v[i];
      tick(6);
      rx = {rx[6:0], so};
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
  endtask
  task automatic cmd(logic [7:0] v, int n);
    logic [7:0] rx;
    sel();
    xb(v, n, rx);
    desel();
  endtask
endmodule

// [test/fac_cmd_handler_tb_top.sv]
// Top testbench for the auxiliary flash command handler.
// Assumes the host model drives the pins; the bench drives core status.
`timescale 1ns/10ps
module fac_cmd_handler_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic chip_select_n, sclk, si, so, so_oe;
  logic [2:0] upper_data_lines;
  logic continuous_program_mode = 1'b0, core_busy = 1'b0, program_active = 1'b0, erase_active = 1'b0;
  logic ready_busy_out_enable, reset_armed, soft_reset, op_abort, reset_recovering;
  logic [7:0] rx;
  int fail_count = 0, cmp_count = 0, n_rst = 0, n_abort = 0, rec_len = 0;
  always #5 mclk = ~mclk;
  fac_cmd_handler u_fac_cmd_handler (.*);
  fac_host_model u_fac_host_model (.*);
  always @(posedge mclk) begin
    n_rst += (soft_reset === 1'b1);
    n_abort += (op_abort === 1'b1);
    rec_len += (reset_recovering === 1'b1);
  end
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic c(logic [7:0] v, int n = 8);
    u_fac_host_model.cmd(v, n);
  endtask
  task automatic t_table();
    logic [7:0] hd [0:4] = '{fac_pkg::OP_PARAM_READ, 8'h00, 8'h00, 8'h04, 8'hC3};
    logic [7:0] ex [0:20] = '{8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00,
      8'hFF, fac_pkg::MAKER_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF};
    u_fac_host_model.sel();
    foreach (hd[i]) u_fac_host_model.xb(hd[i], 8, rx);
    for (int i = 0; i < 21; i++) begin
      u_fac_host_model.xb(8'h00, 8, rx);
      chk(rx, ex[i]);
    end
    u_fac_host_model.xb(8'h00, 3, rx);
    u_fac_host_model.desel();
    chk(so_oe, 1'b0);
  endtask
  task automatic t_rb();
    continuous_program_mode <= 1'b1;
    core_busy <= 1'b1;
    c(fac_pkg::OP_RB_ENABLE);
    chk({ready_busy_out_enable, so_oe, so}, 3'b110);
    core_busy <= 1'b0;
    u_fac_host_model.tick(3);
    chk(so, 1'b1);
    u_fac_host_model.sel();
    u_fac_host_model.xb(fac_pkg::OP_RB_DISABLE, 8, rx);
    u_fac_host_model.xb(8'h00, 1, rx);
    u_fac_host_model.desel();
    c(fac_pkg::OP_RB_DISABLE, 5);
    chk(ready_busy_out_enable, 1'b1);
    c(fac_pkg::OP_RB_DISABLE);
    chk({ready_busy_out_enable, so_oe}, 2'b00);
    c(fac_pkg::OP_RB_ENABLE, 7);
    chk(ready_busy_out_enable, 1'b0);
  endtask
  task automatic t_reset();
    int l1;
    c(fac_pkg::OP_RESET_ARM);
    c(fac_pkg::OP_NO_OPERATION);
    chk(reset_armed, 1'b0);
    c(fac_pkg::OP_RESET);
    c(fac_pkg::OP_RESET_ARM);
    c(fac_pkg::OP_RB_ENABLE);
    c(fac_pkg::OP_RESET);
    chk(8'(n_rst), 8'h00);
    c(fac_pkg::OP_RESET_ARM);
    chk(reset_armed, 1'b1);
    c(fac_pkg::OP_NO_OPERATION);
    chk(ready_busy_out_enable, 1'b1);
    for (int k = 0; k < 2; k++) begin
      program_active <= (k == 0);
      erase_active <= (k == 1);
      c(fac_pkg::OP_RESET_ARM);
      rec_len = 0;
      c(fac_pkg::OP_RESET);
      chk({8'(n_abort), ready_busy_out_enable}, {8'(k + 1), 1'b0});
      for (int i = 0; i < 3000 && reset_recovering !== 1'b0; i++) u_fac_host_model.tick(1);
      if (k == 0) l1 = rec_len;
    end
    chk(8'(n_rst), 8'h02);
    chk(l1 > rec_len, 1'b1);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    u_fac_host_model.tick(4);
    t_table();
    t_rb();
    t_reset();
    finish_test();
  end
  initial begin
    #600000;
    fail_count++;
    finish_test();
  end
endmodule
bind fac_cmd_handler fac_cmd_asserts u_fac_cmd_asserts (.*);
